// file: src/dual_counter_host.sv
// Host end: AHB-Lite register slave that forwards events, stores, clears and reads the counts.
// Assumes one hclk for bus and link; event inputs are synchronous pulses or levels.
`timescale 1ns/10ps

module dual_counter_host
	import dual_counter_pkg::*;
(
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic [1:0]         hresp,
	output logic [31:0]        hrdata,
	input  wire logic          event_a,
	input  wire logic          event_b,
	counter_link_if.host       link
);
	import dual_counter_pkg::*;

	logic               wr_pend_q;
	logic [7:0]         wr_addr_q;
	logic               chain_q;
	logic               done_q;
	host_state_t        state_q;
	logic [TMR_W-1:0]   tmr_q;
	logic [1:0]         idx_q;
	logic [STORE_W-1:0] snap_q;
	logic               clk_a_q;
	logic               clk_b_q;
	logic               gate_q;
	logic               store_q;
	logic               clear_n_q;
	logic [3:0]         sel_n_q;
	logic               accept;
	logic               cmd_store;
	logic               cmd_clear;
	logic               busy;

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY
	assign accept    = hsel & hready & htrans[1];
	assign busy      = (state_q != ST_IDLE);
	assign cmd_store = wr_pend_q & (wr_addr_q == REG_CMD) & hwdata[CMD_STORE_BIT] & ~busy;
	assign cmd_clear = wr_pend_q & (wr_addr_q == REG_CMD) & hwdata[CMD_CLEAR_BIT] & ~busy;

	// Write address held into the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= REG_CTRL;
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
		else
		begin
			wr_pend_q <= accept & hwrite;
			wr_addr_q <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
	end

	// Read data registered in the address phase; unmapped offsets read zero
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= WORD_ZERO;
		else if (accept && !hwrite)
			unique case (haddr[7:0])
				REG_CTRL:    hrdata <= {31'h0000_0000, chain_q};
				REG_COUNT_A: hrdata <= {16'h0000, snap_q[A_LOW_LSB +: COUNT_W]};
				REG_COUNT_B: hrdata <= {16'h0000, snap_q[B_LOW_LSB +: COUNT_W]};
				REG_STATUS:  hrdata <= {30'h0000_0000, done_q, busy};
				default:     hrdata <= WORD_ZERO;
			endcase
	end

	// Chain mode control
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			chain_q <= 1'b0;
		else if (wr_pend_q && wr_addr_q == REG_CTRL)
			chain_q <= hwdata[CTRL_CHAIN_BIT];
	end

	// Done flag: set when a readout ends, cleared by writing a one; set wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			done_q <= 1'b0;
		else if (state_q == ST_SEL && tmr_q == TMR_W'(SEL_CYC - 1) && idx_q == 2'h3)
			done_q <= 1'b1;
		else if (wr_pend_q && wr_addr_q == REG_STATUS && hwdata[STAT_DONE_BIT])
			done_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Count clocks and gate. In chain mode event_a feeds both clocks and carry A gates B;
	// otherwise the gate is held low so B counts on its own.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clk_a_q <= 1'b0;
			clk_b_q <= 1'b0;
			gate_q  <= 1'b0;
		end
		else
		begin
			clk_a_q <= event_a;
			clk_b_q <= chain_q ? event_a : event_b;
			gate_q  <= chain_q ? link.carry_out_a_n : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: store pulse, then four byte reads, each after a Z period
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q <= ST_IDLE;
			tmr_q   <= '0;
			idx_q   <= 2'h0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					tmr_q <= '0;
					idx_q <= 2'h0;
					if (cmd_clear)
						state_q <= ST_CLEAR;
					else if (cmd_store)
						state_q <= ST_STORE;
				end
				ST_STORE, ST_CLEAR:
				begin
					if (tmr_q == TMR_W'((state_q == ST_STORE ? STORE_CYC : CLEAR_CYC) - 1))
					begin
						tmr_q   <= '0;
						state_q <= (state_q == ST_STORE) ? ST_GAP : ST_IDLE;
					end
					else
						tmr_q <= tmr_q + 1'b1;
				end
				ST_GAP:
				begin
					if (tmr_q == TMR_W'(Z_CYC - 1))
					begin
						tmr_q   <= '0;
						state_q <= ST_SEL;
					end
					else
						tmr_q <= tmr_q + 1'b1;
				end
				ST_SEL:
				begin
					if (tmr_q == TMR_W'(SEL_CYC - 1))
					begin
						tmr_q   <= '0;
						idx_q   <= idx_q + 1'b1;
						state_q <= (idx_q == 2'h3) ? ST_IDLE : ST_GAP;
					end
					else
						tmr_q <= tmr_q + 1'b1;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Pin drive: selects come up the cycle after each gap ends
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			store_q   <= 1'b0;
			clear_n_q <= 1'b1;
			sel_n_q   <= SEL_NONE;
		end
		else
		begin
			store_q   <= (state_q == ST_IDLE) & cmd_store & ~cmd_clear;
			clear_n_q <= ~((state_q == ST_IDLE) & cmd_clear);
			if (state_q == ST_GAP && tmr_q == TMR_W'(Z_CYC - 1))
				sel_n_q <= ~(4'h1 << idx_q);
			else if (state_q == ST_SEL && tmr_q == TMR_W'(SEL_CYC - 1))
				sel_n_q <= SEL_NONE;
		end
	end

	// Capture each byte on the last select cycle, when the device output has settled
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			snap_q <= STORE_ZERO;
		else if (state_q == ST_SEL && tmr_q == TMR_W'(SEL_CYC - 1))
			snap_q[{idx_q, 3'h0} +: BYTE_W] <= link.byte_bus;
	end

	assign link.count_clock_a     = clk_a_q;
	assign link.count_clock_b     = clk_b_q;
	assign link.clock_b_gate_n    = gate_q;
	assign link.store_clock       = store_q;
	assign link.counter_clear_n   = clear_n_q;
	assign link.sel_a_low_byte_n  = sel_n_q[0];
	assign link.sel_a_high_byte_n = sel_n_q[1];
	assign link.sel_b_low_byte_n  = sel_n_q[2];
	assign link.sel_b_high_byte_n = sel_n_q[3];

endmodule

// file: src/dual_counter_pkg.sv
// Shared constants for the dual counter with byte readout and its host controller.
// Assumes a single 10 MHz clock (hclk) that both ends run on.
package dual_counter_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Counter and storage geometry
	localparam int COUNT_W = 16;
	localparam int BYTE_W  = 8;
	localparam int STORE_W = 2 * COUNT_W;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_FULL = 16'hFFFF;
	localparam logic [COUNT_W-1:0] COUNT_ONE  = 16'h0001;
	localparam logic [STORE_W-1:0] STORE_ZERO = 32'h0000_0000;
	localparam logic [BYTE_W-1:0]  BYTE_ZERO  = 8'h00;

	// Byte positions inside the 32-bit storage register
	localparam int A_LOW_LSB  = 0;
	localparam int A_HIGH_LSB = 8;
	localparam int B_LOW_LSB  = 16;
	localparam int B_HIGH_LSB = 24;

	// Select codes: bit order {b_high, b_low, a_high, a_low}, active low
	localparam logic [3:0] SEL_NONE   = 4'hF;
	localparam logic [3:0] SEL_A_LOW  = 4'hE;
	localparam logic [3:0] SEL_A_HIGH = 4'hD;
	localparam logic [3:0] SEL_B_LOW  = 4'hB;
	localparam logic [3:0] SEL_B_HIGH = 4'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: figures in ns, counts derived from the clock period
	localparam int CLK_PERIOD_NS = 100;
	localparam int Z_PERIOD_NS   = 200;
	localparam int CLEAR_LOW_NS  = 20;
	localparam int STORE_HIGH_NS = 10;
	localparam int Z_CYC     = (Z_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_CYC = (CLEAR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STORE_CYC = (STORE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Select held two cycles because the device registers its output byte
	localparam int SEL_CYC   = 2;
	localparam int TMR_W     = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Host register map (AHB-Lite, word aligned)
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_CMD     = 8'h04;
	localparam logic [7:0] REG_COUNT_A = 8'h08;
	localparam logic [7:0] REG_COUNT_B = 8'h0C;
	localparam logic [7:0] REG_STATUS  = 8'h10;
	localparam int CTRL_CHAIN_BIT = 0;
	localparam int CMD_STORE_BIT  = 0;
	localparam int CMD_CLEAR_BIT  = 1;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_DONE_BIT  = 1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

	// Host sequencer states, Gray along store -> gap -> select
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_STORE = 3'h1,
		ST_GAP   = 3'h3,
		ST_SEL   = 3'h2,
		ST_CLEAR = 3'h4
	} host_state_t;

endpackage

// file: src/counter_link_if.sv
// Pin-level link between the dual counter device and its host controller.
// Assumes both ends sample the pins on the same hclk; the released byte bus reads as zero here.
`timescale 1ns/10ps
interface counter_link_if;
	import dual_counter_pkg::*;

	logic              count_clock_a;
	logic              count_clock_b;
	logic              clock_b_gate_n;
	logic              counter_clear_n;
	logic              store_clock;
	logic              sel_a_low_byte_n;
	logic              sel_a_high_byte_n;
	logic              sel_b_low_byte_n;
	logic              sel_b_high_byte_n;
	logic [BYTE_W-1:0] byte_out_bus;
	logic              byte_out_oe;
	logic              carry_out_a_n;
	wire  [BYTE_W-1:0] byte_bus;

	// Bus as the host sees it; only the enable tells a driven byte from a released bus
	assign byte_bus = byte_out_oe ? byte_out_bus : BYTE_ZERO;

	modport device (
		input  count_clock_a,
		input  count_clock_b,
		input  clock_b_gate_n,
		input  counter_clear_n,
		input  store_clock,
		input  sel_a_low_byte_n,
		input  sel_a_high_byte_n,
		input  sel_b_low_byte_n,
		input  sel_b_high_byte_n,
		output byte_out_bus,
		output byte_out_oe,
		output carry_out_a_n
	);

	modport host (
		output count_clock_a,
		output count_clock_b,
		output clock_b_gate_n,
		output counter_clear_n,
		output store_clock,
		output sel_a_low_byte_n,
		output sel_a_high_byte_n,
		output sel_b_low_byte_n,
		output sel_b_high_byte_n,
		input  byte_bus,
		input  carry_out_a_n
	);

endinterface

// file: src/count16_unit.sv
// One 16-bit up counter with count-clock edge detection, active-low gate and clear.
// Assumes count_clock is synchronous to hclk and clr_n is an asynchronous active-low clear.
`timescale 1ns/10ps
module count16_unit
	import dual_counter_pkg::*;
(
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               clr_n,
	input  wire logic               count_clock,
	input  wire logic               gate_n,
	output logic [COUNT_W-1:0]      value_q
);

	logic clock_prev_q;
	logic rise;

	////////////////////////////////////////////////////////////////////////////////
	// Previous level of the count clock; kept on hresetn only so a clear makes no false edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			clock_prev_q <= 1'b0;
		else
			clock_prev_q <= count_clock;
	end

	assign rise = count_clock & ~clock_prev_q;

	// Count on each enabled rising edge, wrap from full count to zero
	always_ff @(posedge hclk or negedge clr_n)
	begin
		if (!clr_n)
			value_q <= COUNT_ZERO;
		else if (rise && !gate_n)
			value_q <= value_q + COUNT_ONE;
	end

endmodule

// file: src/dual_counter_device.sv
// Device end: two 16-bit counters, shared 32-bit storage register and a byte-wide readout.
// Assumes all link pins are synchronous to hclk; hresetn is the asynchronous power-on reset.
`timescale 1ns/10ps

module dual_counter_device
	import dual_counter_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	counter_link_if.device  link
);
	import dual_counter_pkg::*;

	logic [COUNT_W-1:0] count_a;
	logic [COUNT_W-1:0] count_b;
	logic               clear_n;
	logic               store_prev_q;
	logic               store_rise;
	logic [STORE_W-1:0] store_q;
	logic [3:0]         sel_n;
	logic [BYTE_W-1:0]  byte_d;
	logic               oe_d;
	logic [BYTE_W-1:0]  byte_q;
	logic               oe_q;
	logic               carry_n_q;

	////////////////////////////////////////////////////////////////////////////////
	// Counters
	// Either reset or the clear pin zeroes the counts; both act without the clock
	assign clear_n = hresetn & link.counter_clear_n;

	// Counter A counts freely, so its gate is tied active
	count16_unit u_count_a (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.clr_n       (clear_n),
		.count_clock (link.count_clock_a),
		.gate_n      (1'b0),
		.value_q     (count_a)
	);

	// Counter B obeys its gate; chaining relies on the host wiring carry A here
	count16_unit u_count_b (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.clr_n       (clear_n),
		.count_clock (link.count_clock_b),
		.gate_n      (link.clock_b_gate_n),
		.value_q     (count_b)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Carry of counter A, registered so the pin comes straight from a flop.
	// It trails the count by one cycle; count clocks must be spaced to allow for it.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			carry_n_q <= 1'b1;
		else
			carry_n_q <= (count_a == COUNT_FULL) ? 1'b0 : 1'b1;
	end

	assign link.carry_out_a_n = carry_n_q;

	////////////////////////////////////////////////////////////////////////////////
	// Storage register
	// Store clock edge detection; the pin is sampled like the count clocks
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			store_prev_q <= 1'b0;
		else
			store_prev_q <= link.store_clock;
	end

	assign store_rise = link.store_clock & ~store_prev_q;

	// Counter B in the upper half, counter A in the lower half; held between edges.
	// The clear pin does not touch it, so a stored snapshot survives a clear.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			store_q <= STORE_ZERO;
		else if (store_rise)
			store_q <= {count_b, count_a};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Byte readout
	assign sel_n = {link.sel_b_high_byte_n, link.sel_b_low_byte_n,
	                link.sel_a_high_byte_n, link.sel_a_low_byte_n};

	// One select low drives one byte; any other code leaves the bus floating.
	// Floating on a double select avoids two bytes fighting on the wire.
	always_comb
	begin
		byte_d = BYTE_ZERO;
		oe_d   = 1'b0;
		unique case (sel_n)
			SEL_A_LOW:
			begin
				byte_d = store_q[A_LOW_LSB +: BYTE_W];
				oe_d   = 1'b1;
			end
			SEL_A_HIGH:
			begin
				byte_d = store_q[A_HIGH_LSB +: BYTE_W];
				oe_d   = 1'b1;
			end
			SEL_B_LOW:
			begin
				byte_d = store_q[B_LOW_LSB +: BYTE_W];
				oe_d   = 1'b1;
			end
			SEL_B_HIGH:
			begin
				byte_d = store_q[B_HIGH_LSB +: BYTE_W];
				oe_d   = 1'b1;
			end
			SEL_NONE:
			begin
				byte_d = BYTE_ZERO;
				oe_d   = 1'b0;
			end
			default:
			begin
				byte_d = BYTE_ZERO;
				oe_d   = 1'b0;
			end
		endcase
	end

	// Output byte and its enable, one cycle behind the selects
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			byte_q <= BYTE_ZERO;
			oe_q   <= 1'b0;
		end
		else
		begin
			byte_q <= byte_d;
			oe_q   <= oe_d;
		end
	end

	assign link.byte_out_bus = byte_q;
	assign link.byte_out_oe  = oe_q;

endmodule

// file: tb/dual_counter_asserts.sv
// Checker for the link between the dual counter device and its host controller.
// Assumes it watches the link signals on hclk; it keeps its own copy of both counts.
`timescale 1ns/10ps
module dual_counter_asserts (
	input wire logic                           hclk,
	input wire logic                           hresetn,
	input wire logic                           count_clock_a,
	input wire logic                           count_clock_b,
	input wire logic                           clock_b_gate_n,
	input wire logic                           counter_clear_n,
	input wire logic                           store_clock,
	input wire logic                           sel_a_low_byte_n,
	input wire logic                           sel_a_high_byte_n,
	input wire logic                           sel_b_low_byte_n,
	input wire logic                           sel_b_high_byte_n,
	input wire logic [dual_counter_pkg::BYTE_W-1:0] byte_out_bus,
	input wire logic                           byte_out_oe,
	input wire logic                           carry_out_a_n
);
	import dual_counter_pkg::*;

	logic [3:0]         sel;
	logic               one_sel;
	logic [COUNT_W-1:0] a_q;
	logic [COUNT_W-1:0] b_q;
	logic [STORE_W-1:0] st_q;
	logic               ca_q;
	logic               cb_q;
	logic               sc_q;
	logic               ref_clr_n;

	assign sel     = {sel_b_high_byte_n, sel_b_low_byte_n, sel_a_high_byte_n, sel_a_low_byte_n};
	assign one_sel = $onehot(~sel);

	////////////////////////////////////////////////////////////////////////////////
	// Previous pin levels, so rises are seen the way the device sees them
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ca_q <= 1'b0;
			cb_q <= 1'b0;
			sc_q <= 1'b0;
		end
		else
		begin
			ca_q <= count_clock_a;
			cb_q <= count_clock_b;
			sc_q <= store_clock;
		end
	end

	// Reference counts; the clear acts at once, as it does in the device
	assign ref_clr_n = hresetn & counter_clear_n;

	always_ff @(posedge hclk or negedge ref_clr_n)
	begin
		if (!ref_clr_n)
		begin
			a_q <= COUNT_ZERO;
			b_q <= COUNT_ZERO;
		end
		else
		begin
			if (count_clock_a && !ca_q)
				a_q <= a_q + COUNT_ONE;
			if (count_clock_b && !cb_q && !clock_b_gate_n)
				b_q <= b_q + COUNT_ONE;
		end
	end

	// Reference storage, copied only on a store rise
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_q <= STORE_ZERO;
		else if (store_clock && !sc_q)
			st_q <= {b_q, a_q};
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking main_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence sel_held(logic [3:0] code);
		sel == code ##1 sel == code;
	endsequence

	sequence store_edge;
		$rose(store_clock);
	endsequence

	// The byte is registered, so it is judged once the select has stood two samples
	property p_byte(logic [3:0] code, logic [7:0] exp);
		sel_held(code) |-> byte_out_oe && byte_out_bus == exp;
	endproperty

	a_a_low_byte: assert property (p_byte(SEL_A_LOW, st_q[A_LOW_LSB +: BYTE_W]))
		else $error("a low byte wrong");
	a_a_high_byte: assert property (p_byte(SEL_A_HIGH, st_q[A_HIGH_LSB +: BYTE_W]))
		else $error("a high byte wrong");
	a_b_low_byte: assert property (p_byte(SEL_B_LOW, st_q[B_LOW_LSB +: BYTE_W]))
		else $error("b low byte wrong");
	a_b_high_byte: assert property (p_byte(SEL_B_HIGH, st_q[B_HIGH_LSB +: BYTE_W]))
		else $error("b high byte wrong");
	a_bus_float: assert property (sel_held(SEL_NONE) |-> !byte_out_oe)
		else $error("bus driven with no select");
	a_one_byte: assert property (byte_out_oe |-> $past(one_sel))
		else $error("bus driven without a single select");
	a_one_select: assert property ($onehot0(~sel))
		else $error("two selects low");
	a_carry_level: assert property ($stable(a_q) [*3] |-> carry_out_a_n == (a_q != COUNT_FULL))
		else $error("carry a level wrong");
	a_store_quiet: assert property (store_edge |-> sel == SEL_NONE && !byte_out_oe)
		else $error("store while bus selected");
	a_clear_quiet: assert property ($fell(counter_clear_n) |-> (sel == SEL_NONE && !byte_out_oe) [*2])
		else $error("clear while bus selected");
	a_store_pulse: assert property (store_edge |=> $fell(store_clock))
		else $error("store pulse too long");
	a_clear_pulse: assert property ($fell(counter_clear_n) |=> counter_clear_n)
		else $error("clear pulse too long");
endmodule

// file: tb/tb_top.sv
// Testbench: drives the host controller over AHB-Lite and its event inputs, device on the far side.
// Assumes the package, link interface, device, host and checker are compiled before it.
`timescale 1ns/10ps
module tb_top;
	import dual_counter_pkg::*;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = WORD_ZERO;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = WORD_ZERO;
	logic        hreadyout;
	logic [1:0]  hresp;
	logic [31:0] hrdata;
	logic        event_a = 1'b0;
	logic        event_b = 1'b0;
	logic [31:0] rd;
	int          errors = 0;
	int          cmp_count = 0;

	counter_link_if link ();

	dual_counter_device dual_counter_device_i (.hclk(hclk), .hresetn(hresetn), .link(link));

	// The only slave, so its ready is the bus ready
	dual_counter_host dual_counter_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_a(event_a), .event_b(event_b),
		.link(link));

	dual_counter_asserts dual_counter_asserts_i (.hclk(hclk), .hresetn(hresetn),
		.count_clock_a(link.count_clock_a), .count_clock_b(link.count_clock_b),
		.clock_b_gate_n(link.clock_b_gate_n), .counter_clear_n(link.counter_clear_n),
		.store_clock(link.store_clock), .sel_a_low_byte_n(link.sel_a_low_byte_n),
		.sel_a_high_byte_n(link.sel_a_high_byte_n), .sel_b_low_byte_n(link.sel_b_low_byte_n),
		.sel_b_high_byte_n(link.sel_b_high_byte_n), .byte_out_bus(link.byte_out_bus),
		.byte_out_oe(link.byte_out_oe), .carry_out_a_n(link.carry_out_a_n));

	always #50 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: %s saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	// One single transfer; waits on ready instead of assuming a latency
	task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {24'h00_0000, addr};
		hwrite <= wr;
		do
			@(posedge hclk);
		while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wdata;
		do
			@(posedge hclk);
		while (hreadyout !== 1'b1);
		rd = hrdata;
		check({30'h0000_0000, hresp}, {30'h0000_0000, HRESP_OKAY}, "response");
	endtask

	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		ahb(1'b1, addr, data);
	endtask

	task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp, input string what);
		ahb(1'b0, addr, WORD_ZERO);
		check(rd, exp, what);
	endtask

	// Polls a status bit under a bounded count
	task automatic wait_bit(input int idx, input logic val);
		int n;
		n = 0;
		ahb(1'b0, REG_STATUS, WORD_ZERO);
		while (rd[idx] !== val && n < 200)
		begin
			n++;
			ahb(1'b0, REG_STATUS, WORD_ZERO);
		end
		check({31'h0000_0000, rd[idx]}, {31'h0000_0000, val}, "status bit");
	endtask

	// Store, wait for the four-byte readout, then compare both counts
	task automatic store_read(input logic [15:0] exp_a, input logic [15:0] exp_b);
		wr(REG_CMD, 32'h0000_0001);
		wait_bit(STAT_DONE_BIT, 1'b1);
		wr(REG_STATUS, 32'h0000_0002);
		rdchk(REG_STATUS, WORD_ZERO, "done cleared");
		rdchk(REG_COUNT_A, {16'h0000, exp_a}, "count a");
		rdchk(REG_COUNT_B, {16'h0000, exp_b}, "count b");
	endtask

	// Events spaced six cycles apart, wide enough for the chained carry lag
	task automatic pulse(input logic a, input logic b, input int n);
		repeat (n)
		begin
			@(posedge hclk);
			event_a <= a;
			event_b <= b;
			repeat (3)
				@(posedge hclk);
			event_a <= 1'b0;
			event_b <= 1'b0;
			repeat (2)
				@(posedge hclk);
		end
	endtask

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (2)
			@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check({31'h0000_0000, link.byte_out_oe}, WORD_ZERO, "bus at rest");
		rdchk(REG_STATUS, WORD_ZERO, "status at reset");
		rdchk(REG_COUNT_A, WORD_ZERO, "count a at reset");
		rdchk(8'h20, WORD_ZERO, "unmapped read");
		wr(8'h20, 32'hFFFF_FFFF);
		rdchk(REG_CTRL, WORD_ZERO, "ctrl after unmapped write");
		$display("test reset done");
		// Counts above 255 so a swapped byte half shows up
		pulse(1'b1, 1'b1, 258);
		pulse(1'b1, 1'b0, 44);
		pulse(1'b0, 1'b1, 3);
		store_read(16'h012E, 16'h0105);
		$display("test independent count done");
		// Store and clear together: clear wins
		wr(REG_CMD, 32'h0000_0003);
		wait_bit(STAT_BUSY_BIT, 1'b0);
		store_read(COUNT_ZERO, COUNT_ZERO);
		$display("test clear done");
		// Chained: B waits on carry A, so it stays put below full count
		wr(REG_CTRL, 32'h0000_0001);
		rdchk(REG_CTRL, 32'h0000_0001, "ctrl chain");
		pulse(1'b1, 1'b1, 6);
		store_read(16'h0006, COUNT_ZERO);
		$display("test chain done");
		// A clear sent while a store runs must be ignored
		wr(REG_CTRL, WORD_ZERO);
		wr(REG_CMD, 32'h0000_0001);
		wr(REG_CMD, 32'h0000_0002);
		wait_bit(STAT_DONE_BIT, 1'b1);
		wr(REG_STATUS, 32'h0000_0002);
		pulse(1'b0, 1'b1, 2);
		store_read(16'h0006, 16'h0002);
		$display("test busy refusal done");
		give_verdict();
	end

	// Cuts a hang short; the tests need well under a fifth of this span
	initial
	begin
		#2_000_000;
		errors++;
		give_verdict();
	end
endmodule
